// ===== fbx_defs.svh
// constants for the fieldbus exchange memory: offsets, fields, reset values, timing
`ifndef FBX_DEFS_SVH
`define FBX_DEFS_SVH
`define FBX_AREA_BYTES 11'h400
`define FBX_MEM_BYTES 12'h800
`define FBX_STATE_OFS 11'h400
`define FBX_STATE_OFS_HI 11'h401
`define FBX_LIST_OFS 11'h402
`define FBX_LIST_LAST 11'h411
`define FBX_MODE_LSB 0
`define FBX_MODE_MSB 1
`define FBX_MODE_RESET 2'h1
`define FBX_CLK_MHZ 250
`define FBX_MS_NS 1000000
`define FBX_CLK_NS 4
`define FBX_MS_CYCLES (`FBX_MS_NS / `FBX_CLK_NS)
`define FBX_SLOT_UNIT_NS 100000
`define FBX_SLOT_UNIT_CYCLES (`FBX_SLOT_UNIT_NS / `FBX_CLK_NS)
`define FBX_TIMEOUT_MIN_MS 16'h0064
`define FBX_TIMEOUT_MAX_MS 16'hEA60
`define FBX_SDR_MIN 8'h0B
`define FBX_SDR_MAX 8'hFF
`endif

// ===== fbx_pkg.sv
// types shared by the fieldbus exchange memory files
package fbx_pkg;
	typedef enum logic [1:0]
	{
		FBX_MODE_OFFLINE = 2'h0,
		FBX_MODE_STOP = 2'h1,
		FBX_MODE_CLEAR = 2'h2,
		FBX_MODE_OPERATE = 2'h3
	} fbx_mode_t;
	typedef enum logic [1:0]
	{
		FBX_POLL_IDLE = 2'h0,
		FBX_POLL_WAIT = 2'h1,
		FBX_POLL_RETRY = 2'h3,
		FBX_POLL_GIVEUP = 2'h2
	} fbx_poll_t;
	typedef struct packed
	{
		logic [10:0] addr;
		logic [7:0] data;
	} fbx_wr_t;
	typedef struct packed
	{
		logic [15:0] slot_units;
		logic [7:0] min_station_reply_delay;
		logic [7:0] max_station_reply_delay;
		logic [15:0] target_token_rotation;
		logic [7:0] station_scan_interval;
		logic [6:0] highest_station_number;
		logic [3:0] retry_limit;
	} fbx_bus_cfg_t;
endpackage

// ===== fbx_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module fbx_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 4
)(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = cnt_q != (AW+1)'(DEPTH);
	assign out_valid_o = cnt_q != '0;
	assign out_data_o = mem_q[rd_q];
	always_ff @(posedge clk_sys_i)
	begin
		if (push)
			mem_q[wr_q] <= in_data_i;
		if (!reset_n_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ===== fbx_fault_watch.sv
// per-module watchdog that selects substitute bytes after an update timeout
`timescale 1ns/1ps
`include "fbx_defs.svh"
module fbx_fault_watch #(
	parameter int MS_CYCLES = `FBX_MS_CYCLES
)(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic [15:0] timeout_ms_i,
	input wire logic touch_i,
	output logic fault_o
);
	logic [31:0] tick_q;
	logic [15:0] ms_q;
	// zero or out-of-range timeout disables monitoring; last values stay
	wire enabled = timeout_ms_i >= `FBX_TIMEOUT_MIN_MS && timeout_ms_i <= `FBX_TIMEOUT_MAX_MS;
	wire tick_end = tick_q == 32'(MS_CYCLES - 1);
	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i || touch_i || !enabled)
		begin
			// any access restarts the timer and returns live data
			tick_q <= '0;
			ms_q <= '0;
			fault_o <= 1'b0;
		end
		else
		begin
			tick_q <= tick_end ? '0 : tick_q + 32'h1;
			if (tick_end && ms_q != timeout_ms_i)
				ms_q <= ms_q + 16'h1;
			fault_o <= ms_q == timeout_ms_i;
		end
	end
endmodule

// ===== fbx_exchange.sv
// shared exchange memory between the ethernet controller and the fieldbus master
// How it works
// - one 2048-byte memory, output area and input area, carries all cyclic data.
// - each area holds 1024 bytes of cyclic slave data.
// - input bytes 1024-1025 report master mode; then a data exchange list.
// - writing output byte 1024 sets the master mode; a write to byte 1025 is ignored.
// - output area feeds fieldbus; fieldbus data lands in the input area.
// - every output module keeps one substitute byte per data byte.
// - a module left untouched past its timeout outputs substitute bytes.
// - timeout zero or outside 100..60000 ms disables monitoring.
// - slot timer in 100 us units bounds the wait for a reply.
// - unanswered requests repeat at most the retry limit, then give up.
// - station scan runs once per configured number of token rounds.
// - addressed stations above the highest station number are flagged as not ok.
// - a target token rotation time, counted in slot units, flags a late token rotation.
// - a saved configuration is stored persistently, then the device restarts.
`timescale 1ns/1ps
`include "fbx_defs.svh"
module fbx_exchange #(
	parameter int MODULES = 4,
	parameter int MOD_BYTES = 256,
	parameter int FIFO_DEPTH = 4,
	parameter int MS_CYCLES = `FBX_MS_CYCLES,
	parameter int SLOT_UNIT_CYCLES = `FBX_SLOT_UNIT_CYCLES
)(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// ethernet side
	input wire logic eth_wr_i,
	input wire logic eth_rd_i,
	input wire logic [10:0] eth_addr_i,
	input wire logic [7:0] eth_wdata_i,
	output logic eth_wr_ready_o,
	output logic [7:0] eth_rdata_o,
	// fieldbus side
	input wire logic fb_rd_i,
	input wire logic [10:0] fb_addr_i,
	output logic [7:0] fb_rdata_o,
	input wire logic fb_wr_i,
	input wire logic [10:0] fb_waddr_i,
	input wire logic [7:0] fb_wdata_i,
	input wire logic [127:0] fb_exchange_list_i,
	// configuration
	input wire logic cfg_sub_wr_i,
	input wire logic [10:0] cfg_sub_addr_i,
	input wire logic [7:0] cfg_sub_data_i,
	input wire logic [MODULES*16-1:0] cfg_timeout_ms_i,
	input wire fbx_pkg::fbx_bus_cfg_t cfg_bus_i,
	input wire logic cfg_save_i,
	input wire logic cfg_store_done_i,
	output logic cfg_store_o,
	output logic restart_o,
	// master engine
	output fbx_pkg::fbx_mode_t master_mode_o,
	input wire logic req_start_i,
	input wire logic reply_seen_i,
	input wire logic [6:0] req_station_i,
	input wire logic [7:0] reply_delay_bits_i,
	input wire logic token_round_i,
	output logic req_retry_o,
	output logic req_giveup_o,
	output logic station_ok_o,
	output logic reply_delay_ok_o,
	output logic scan_due_o,
	output logic rotation_late_o,
	output logic [MODULES-1:0] module_fault_o
);
	localparam int MOD_AW = $clog2(MOD_BYTES);
	logic [7:0] out_mem_q [1024];
	logic [7:0] in_mem_q [1024];
	logic [7:0] sub_mem_q [1024];
	fbx_pkg::fbx_mode_t mode_q;
	logic [7:0] eth_rdata_q;
	logic [7:0] fb_rdata_q;
	fbx_pkg::fbx_poll_t poll_q;
	logic [31:0] slot_tick_q;
	logic [15:0] slot_cnt_q;
	logic [3:0] tries_q;
	logic req_retry_q;
	logic req_giveup_q;
	logic [7:0] rounds_q;
	logic scan_due_q;
	logic [31:0] rot_tick_q;
	logic [15:0] rot_cnt_q;
	logic rotation_late_q;
	logic save_busy_q;
	logic cfg_store_q;
	logic restart_q;

	// ethernet writes pass through the fifo so the memory port can be shared
	fbx_pkg::fbx_wr_t wr_in;
	fbx_pkg::fbx_wr_t wr_out;
	logic wr_valid;
	// a command write must wait while a save is pending, which stalls the fifo
	wire wr_is_cmd = wr_out.addr[10];
	wire wr_drain = !(wr_is_cmd && save_busy_q);
	assign wr_in = '{addr: eth_addr_i, data: eth_wdata_i};
	fbx_fifo #(
		.WIDTH($bits(fbx_pkg::fbx_wr_t)),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.in_data_i(wr_in),
		.in_valid_i(eth_wr_i),
		.in_ready_o(eth_wr_ready_o),
		.out_data_o(wr_out),
		.out_valid_o(wr_valid),
		.out_ready_i(wr_drain)
	);
	wire wr_take = wr_valid && wr_drain;
	wire wr_data = wr_take && !wr_out.addr[10];
	wire wr_mode = wr_take && wr_out.addr == `FBX_STATE_OFS;
	wire [1:0] wr_mode_val = wr_out.data[`FBX_MODE_MSB:`FBX_MODE_LSB];
	// reserved code 00 is ignored, master stays in its mode
	wire wr_mode_ok = wr_mode && wr_mode_val != 2'h0;

	// ethernet read of the input area, with status word and exchange list
	wire eth_rd_status = eth_addr_i == `FBX_STATE_OFS;
	wire eth_rd_list = eth_addr_i >= `FBX_LIST_OFS && eth_addr_i <= `FBX_LIST_LAST;
	wire [3:0] list_idx = 4'(eth_addr_i - `FBX_LIST_OFS);
	wire [7:0] list_byte = fb_exchange_list_i[list_idx*8 +: 8];
	wire [7:0] eth_rd_val = !eth_addr_i[10] ? in_mem_q[eth_addr_i[9:0]] :
		eth_rd_status ? {6'h00, mode_q} :
		eth_rd_list ? list_byte : 8'h00;

	// per-module fault watch; touch is any ethernet access to the module's block
	wire [MODULES-1:0] touch;
	wire [MODULES-1:0] fault;
	genvar g;
	generate
		for (g = 0; g < MODULES; g++)
		begin : g_mod
			wire wr_hit = wr_data && wr_out.addr[9:MOD_AW] == (10-MOD_AW)'(g);
			wire rd_hit = eth_rd_i && !eth_addr_i[10] && eth_addr_i[9:MOD_AW] == (10-MOD_AW)'(g);
			assign touch[g] = wr_hit || rd_hit;
			fbx_fault_watch #(
				.MS_CYCLES(MS_CYCLES)
			) u_watch (
				.clk_sys_i(clk_sys_i),
				.reset_n_i(reset_n_i),
				.timeout_ms_i(cfg_timeout_ms_i[g*16 +: 16]),
				.touch_i(touch[g]),
				.fault_o(fault[g])
			);
		end
	endgenerate

	// fieldbus read of the output area, substitute bytes on fault
	wire [9:0] fb_idx = fb_addr_i[9:0];
	wire fb_mod_fault = fault[fb_idx[9:MOD_AW]];
	wire [7:0] fb_rd_val = fb_addr_i[10] ? 8'h00 :
		fb_mod_fault ? sub_mem_q[fb_idx] : out_mem_q[fb_idx];

	// memories: one byte array per direction plus substitute bytes
	always_ff @(posedge clk_sys_i)
	begin
		if (wr_data)
			out_mem_q[wr_out.addr[9:0]] <= wr_out.data;
		if (fb_wr_i && !fb_waddr_i[10])
			in_mem_q[fb_waddr_i[9:0]] <= fb_wdata_i;
		if (cfg_sub_wr_i && !cfg_sub_addr_i[10])
			sub_mem_q[cfg_sub_addr_i[9:0]] <= cfg_sub_data_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
		begin
			mode_q <= fbx_pkg::fbx_mode_t'(`FBX_MODE_RESET);
			eth_rdata_q <= 8'h00;
			fb_rdata_q <= 8'h00;
		end
		else
		begin
			if (wr_mode_ok)
				mode_q <= fbx_pkg::fbx_mode_t'(wr_mode_val);
			if (eth_rd_i)
				eth_rdata_q <= eth_rd_val;
			if (fb_rd_i)
				fb_rdata_q <= fb_rd_val;
		end
	end

	// request poll: slot timer, retries, give-up
	wire slot_tick_end = slot_tick_q == 32'(SLOT_UNIT_CYCLES - 1);
	wire slot_expired = slot_cnt_q >= cfg_bus_i.slot_units;
	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
		begin
			poll_q <= fbx_pkg::FBX_POLL_IDLE;
			slot_tick_q <= '0;
			slot_cnt_q <= '0;
			tries_q <= '0;
			req_retry_q <= 1'b0;
			req_giveup_q <= 1'b0;
		end
		else
		begin
			req_retry_q <= 1'b0;
			req_giveup_q <= 1'b0;
			case (poll_q)
				fbx_pkg::FBX_POLL_IDLE:
				begin
					slot_tick_q <= '0;
					slot_cnt_q <= '0;
					tries_q <= '0;
					if (req_start_i)
						poll_q <= fbx_pkg::FBX_POLL_WAIT;
				end
				fbx_pkg::FBX_POLL_WAIT:
				begin
					slot_tick_q <= slot_tick_end ? '0 : slot_tick_q + 32'h1;
					if (slot_tick_end)
						slot_cnt_q <= slot_cnt_q + 16'h1;
					if (reply_seen_i)
						poll_q <= fbx_pkg::FBX_POLL_IDLE;
					else if (slot_expired)
						poll_q <= (tries_q < cfg_bus_i.retry_limit) ?
							fbx_pkg::FBX_POLL_RETRY : fbx_pkg::FBX_POLL_GIVEUP;
				end
				fbx_pkg::FBX_POLL_RETRY:
				begin
					tries_q <= tries_q + 4'h1;
					slot_tick_q <= '0;
					slot_cnt_q <= '0;
					req_retry_q <= 1'b1;
					poll_q <= fbx_pkg::FBX_POLL_WAIT;
				end
				fbx_pkg::FBX_POLL_GIVEUP:
				begin
					req_giveup_q <= 1'b1;
					poll_q <= fbx_pkg::FBX_POLL_IDLE;
				end
				default:
					poll_q <= fbx_pkg::FBX_POLL_IDLE;
			endcase
		end
	end

	// token rounds: scan interval and rotation time in slot units
	wire scan_hit = token_round_i && rounds_q + 8'h1 >= cfg_bus_i.station_scan_interval;
	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
		begin
			rounds_q <= '0;
			scan_due_q <= 1'b0;
			rot_tick_q <= '0;
			rot_cnt_q <= '0;
			rotation_late_q <= 1'b0;
		end
		else
		begin
			scan_due_q <= scan_hit;
			if (token_round_i)
				rounds_q <= scan_hit ? 8'h00 : rounds_q + 8'h1;
			rot_tick_q <= (token_round_i || rot_tick_q == 32'(SLOT_UNIT_CYCLES - 1)) ? '0 : rot_tick_q + 32'h1;
			if (token_round_i)
				rot_cnt_q <= '0;
			else if (rot_tick_q == 32'(SLOT_UNIT_CYCLES - 1) && rot_cnt_q != 16'hFFFF)
				rot_cnt_q <= rot_cnt_q + 16'h1;
			rotation_late_q <= rot_cnt_q >= cfg_bus_i.target_token_rotation;
		end
	end

	// save: persist first, restart once the store completes
	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
		begin
			save_busy_q <= 1'b0;
			cfg_store_q <= 1'b0;
			restart_q <= 1'b0;
		end
		else
		begin
			cfg_store_q <= cfg_save_i && !save_busy_q;
			restart_q <= save_busy_q && cfg_store_done_i;
			if (cfg_save_i)
				save_busy_q <= 1'b1;
			else if (cfg_store_done_i)
				save_busy_q <= 1'b0;
		end
	end

	assign eth_rdata_o = eth_rdata_q;
	assign fb_rdata_o = fb_rdata_q;
	assign master_mode_o = mode_q;
	assign req_retry_o = req_retry_q;
	assign req_giveup_o = req_giveup_q;
	assign station_ok_o = req_station_i <= cfg_bus_i.highest_station_number;
	// slave-side delay window, checked only
	assign reply_delay_ok_o = reply_delay_bits_i >= cfg_bus_i.min_station_reply_delay &&
		reply_delay_bits_i <= cfg_bus_i.max_station_reply_delay &&
		reply_delay_bits_i >= `FBX_SDR_MIN && reply_delay_bits_i <= `FBX_SDR_MAX;
	assign scan_due_o = scan_due_q;
	assign rotation_late_o = rotation_late_q;
	assign cfg_store_o = cfg_store_q;
	assign restart_o = restart_q;
	assign module_fault_o = fault;
endmodule

// ===== fbx_exchange_assertions.sv
// port-level assertions for the exchange memory
`timescale 1ns/1ps
module fbx_exchange_assertions (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic eth_wr_i,
	input wire logic eth_rd_i,
	input wire logic [10:0] eth_addr_i,
	input wire logic [7:0] eth_wdata_i,
	input wire logic eth_wr_ready_o,
	input wire logic [7:0] eth_rdata_o,
	input wire logic cfg_save_i,
	input wire logic cfg_store_done_i,
	input wire logic cfg_store_o,
	input wire logic restart_o,
	input wire fbx_pkg::fbx_mode_t master_mode_o,
	input wire logic token_round_i,
	input wire logic scan_due_o,
	input wire logic [6:0] req_station_i,
	input wire fbx_pkg::fbx_bus_cfg_t cfg_bus_i,
	input wire logic station_ok_o,
	input wire logic req_retry_o,
	input wire logic req_giveup_o
);
	logic busy_q;
	logic busy_d;
	logic [2:0] calm_q;
	// mode writes stall while a save is pending and drain late after it, so they are left out
	assign busy_d = cfg_save_i | (busy_q & ~restart_o);
	always_ff @(posedge clk_sys_i)
	begin
		busy_q <= busy_d & reset_n_i;
		calm_q <= !reset_n_i ? 3'h7 : busy_d ? 3'h0 : calm_q + {2'h0, calm_q != 3'h7};
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	sequence mode_wr_s;
		eth_wr_i && eth_wr_ready_o && eth_addr_i == 11'h400 && eth_wdata_i[1:0] != 2'h0 && !busy_d && calm_q >= 3'h5;
	endsequence
	sequence store_s;
		cfg_store_o ##1 !cfg_store_o;
	endsequence
	mode_write_a: assert property (mode_wr_s |-> ##2 master_mode_o == $past(eth_wdata_i[1:0], 2))
		else $error("mode not taken");
	status_read_a: assert property (eth_rd_i && eth_addr_i == 11'h400 |=> eth_rdata_o == {6'h00, $past(master_mode_o)})
		else $error("status byte wrong");
	store_pulse_a: assert property (cfg_save_i && !busy_q |=> store_s)
		else $error("store pulse missing");
	restart_after_a: assert property (cfg_store_done_i && busy_q |=> restart_o ##1 !restart_o)
		else $error("restart pulse missing");
	poll_excl_a: assert property (!(req_retry_o && req_giveup_o))
		else $error("retry with give up");
	giveup_once_a: assert property (req_giveup_o |=> !req_giveup_o [*3])
		else $error("give up repeated");
	scan_cause_a: assert property (scan_due_o |-> $past(token_round_i))
		else $error("scan without round");
	station_bound_a: assert property (station_ok_o == (req_station_i <= cfg_bus_i.highest_station_number))
		else $error("station bound wrong");
endmodule
bind fbx_exchange fbx_exchange_assertions u_chk (
	.clk_sys_i(clk_sys_i),
	.reset_n_i(reset_n_i),
	.eth_wr_i(eth_wr_i),
	.eth_rd_i(eth_rd_i),
	.eth_addr_i(eth_addr_i),
	.eth_wdata_i(eth_wdata_i),
	.eth_wr_ready_o(eth_wr_ready_o),
	.eth_rdata_o(eth_rdata_o),
	.cfg_save_i(cfg_save_i),
	.cfg_store_done_i(cfg_store_done_i),
	.cfg_store_o(cfg_store_o),
	.restart_o(restart_o),
	.master_mode_o(master_mode_o),
	.token_round_i(token_round_i),
	.scan_due_o(scan_due_o),
	.req_station_i(req_station_i),
	.cfg_bus_i(cfg_bus_i),
	.station_ok_o(station_ok_o),
	.req_retry_o(req_retry_o),
	.req_giveup_o(req_giveup_o)
);

// ===== fbx_fb_model.sv
// fieldbus side model: slaves fill inputs, master takes outputs
`timescale 1ns/1ps
module fbx_fb_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] fb_rdata_i,
	output logic fb_rd_o = 1'b0,
	output logic [10:0] fb_addr_o = 11'h000,
	output logic fb_wr_o = 1'b0,
	output logic [10:0] fb_waddr_o = 11'h000,
	output logic [7:0] fb_wdata_o = 8'h00
);
	// one slave: applied outputs under sync, reported inputs under freeze
	localparam int WATCHDOG_NS = 2000;
	logic sync_on = 1'b0;
	logic freeze_on = 1'b0;
	logic [7:0] applied = 8'h00;
	logic [7:0] held = 8'h00;
	logic [7:0] frozen = 8'h00;
	logic [7:0] buffered = 8'h00;
	time last_get = 0;
	// slow is the quiet time after the last frame before the slave listens
	task automatic put(input logic [10:0] a, input logic [7:0] d, input int slow);
		logic [7:0] v;
		repeat (slow) @(posedge clk_sys_i);
		// frozen slaves keep reporting the captured value, newer samples wait
		if (freeze_on)
			buffered = d;
		else
			frozen = d;
		v = frozen;
		@(posedge clk_sys_i);
		fb_wr_o <= 1'b1;
		fb_waddr_o <= a;
		fb_wdata_o <= v;
		@(posedge clk_sys_i);
		fb_wr_o <= 1'b0;
		// released data never repeats the last byte
		fb_wdata_o <= ~v;
	endtask
	task automatic freeze_cmd(input logic on);
		if (on)
			buffered = frozen;
		else
			frozen = buffered;
		freeze_on = on;
	endtask
	task automatic sync_cmd(input logic on);
		applied = held;
		sync_on = on;
	endtask
	task automatic get(input logic [10:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		fb_rd_o <= 1'b1;
		fb_addr_o <= a;
		@(posedge clk_sys_i);
		fb_rd_o <= 1'b0;
		fb_addr_o <= ~a;
		#1 d = fb_rdata_i;
		// long master silence drops the slave to safe outputs first
		if ($time - last_get > WATCHDOG_NS)
			applied = 8'h00;
		last_get = $time;
		// under sync new outputs wait for the next sync or unsync
		held = d;
		if (!sync_on)
			applied = d;
	endtask
endmodule

// ===== fieldbus_gateway_exchange_memory_tb_top.sv
// self-checking bench for the exchange memory
`timescale 1ns/1ps
module fieldbus_gateway_exchange_memory_tb_top;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic eth_wr_i = 1'b0, eth_rd_i = 1'b0, cfg_sub_wr_i = 1'b0, cfg_save_i = 1'b0, cfg_store_done_i = 1'b0;
	logic req_start_i = 1'b0, reply_seen_i = 1'b0, token_round_i = 1'b0, fb_rd_i, fb_wr_i;
	logic [10:0] eth_addr_i = 11'h000, cfg_sub_addr_i = 11'h000, fb_addr_i, fb_waddr_i;
	logic [7:0] eth_wdata_i = 8'h00, cfg_sub_data_i = 8'h00, reply_delay_bits_i = 8'h0B, fb_wdata_i;
	logic [6:0] req_station_i = 7'h7F;
	logic [127:0] fb_exchange_list_i = {8{16'hA5C3}};
	// module 0 at 100 ms, 1 off, 2 out of range, 3 off
	logic [63:0] cfg_timeout_ms_i = 64'h0000_EA61_0000_0064;
	fbx_pkg::fbx_bus_cfg_t cfg_bus_i = {16'h0002, 8'h0B, 8'hFF, 16'h0010, 8'h03, 7'h7E, 4'h2};
	logic eth_wr_ready_o, cfg_store_o, restart_o, req_retry_o, req_giveup_o, station_ok_o;
	logic reply_delay_ok_o, scan_due_o, rotation_late_o;
	logic [7:0] eth_rdata_o, fb_rdata_o;
	logic [3:0] module_fault_o;
	fbx_pkg::fbx_mode_t master_mode_o;
	int err_count = 0;
	int n_tests = 0;
	// short ms and slot units keep the run brief
	fbx_exchange #(
		.MS_CYCLES(10),
		.SLOT_UNIT_CYCLES(5)
	) dut (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.eth_wr_i(eth_wr_i),
		.eth_rd_i(eth_rd_i),
		.eth_addr_i(eth_addr_i),
		.eth_wdata_i(eth_wdata_i),
		.eth_wr_ready_o(eth_wr_ready_o),
		.eth_rdata_o(eth_rdata_o),
		.fb_rd_i(fb_rd_i),
		.fb_addr_i(fb_addr_i),
		.fb_rdata_o(fb_rdata_o),
		.fb_wr_i(fb_wr_i),
		.fb_waddr_i(fb_waddr_i),
		.fb_wdata_i(fb_wdata_i),
		.fb_exchange_list_i(fb_exchange_list_i),
		.cfg_sub_wr_i(cfg_sub_wr_i),
		.cfg_sub_addr_i(cfg_sub_addr_i),
		.cfg_sub_data_i(cfg_sub_data_i),
		.cfg_timeout_ms_i(cfg_timeout_ms_i),
		.cfg_bus_i(cfg_bus_i),
		.cfg_save_i(cfg_save_i),
		.cfg_store_done_i(cfg_store_done_i),
		.cfg_store_o(cfg_store_o),
		.restart_o(restart_o),
		.master_mode_o(master_mode_o),
		.req_start_i(req_start_i),
		.reply_seen_i(reply_seen_i),
		.req_station_i(req_station_i),
		.reply_delay_bits_i(reply_delay_bits_i),
		.token_round_i(token_round_i),
		.req_retry_o(req_retry_o),
		.req_giveup_o(req_giveup_o),
		.station_ok_o(station_ok_o),
		.reply_delay_ok_o(reply_delay_ok_o),
		.scan_due_o(scan_due_o),
		.rotation_late_o(rotation_late_o),
		.module_fault_o(module_fault_o)
	);
	fbx_fb_model fbm (.clk_sys_i(clk_sys_i), .fb_rdata_i(fb_rdata_o), .fb_rd_o(fb_rd_i), .fb_addr_o(fb_addr_i),
		.fb_wr_o(fb_wr_i), .fb_waddr_o(fb_waddr_i), .fb_wdata_o(fb_wdata_i));
	always #2 clk_sys_i = ~clk_sys_i;
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic ew(input logic [10:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		eth_wr_i <= 1'b1;
		eth_addr_i <= a;
		eth_wdata_i <= d;
		#1;
		while (eth_wr_ready_o !== 1'b1)
			@(posedge clk_sys_i) #1;
		@(posedge clk_sys_i);
		eth_wr_i <= 1'b0;
	endtask
	task automatic er(input logic [10:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		eth_rd_i <= 1'b1;
		eth_addr_i <= a;
		@(posedge clk_sys_i);
		eth_rd_i <= 1'b0;
		#1 d = eth_rdata_o;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic t_mode();
		logic [7:0] d;
		for (int m = 1; m < 4; m++)
		begin
			ew(11'h400, 8'hFC | m[7:0]);
			cyc(3);
			chk("mode", 16'(master_mode_o), 16'(m));
			er(11'h400, d);
			chk("status", 16'(d), 16'(m));
		end
		ew(11'h400, 8'h00);
		ew(11'h401, 8'h02);
		cyc(3);
		chk("mode kept", 16'(master_mode_o), 16'h0003);
		er(11'h401, d);
		chk("status high", 16'(d), 16'h0000);
		$display("mode test done");
	endtask
	task automatic t_data();
		logic [7:0] d;
		ew(11'h3FF, 8'hC6);
		cyc(3);
		fbm.get(11'h3FF, d);
		chk("fb out", 16'(d), 16'h00C6);
		fbm.put(11'h3FF, 8'h96, 4);
		cyc(2);
		er(11'h3FF, d);
		chk("eth in", 16'(d), 16'h0096);
		er(11'h402, d);
		chk("list", 16'(d), 16'h00C3);
		fbm.sync_cmd(1'b1);
		ew(11'h3FF, 8'h5A);
		cyc(3);
		fbm.get(11'h3FF, d);
		chk("fb out sync", 16'(d), 16'h005A);
		chk("slave held", 16'(fbm.applied), 16'h00C6);
		fbm.sync_cmd(1'b0);
		chk("slave sync", 16'(fbm.applied), 16'h005A);
		fbm.freeze_cmd(1'b1);
		fbm.put(11'h3FF, 8'h33, 2);
		cyc(2);
		er(11'h3FF, d);
		chk("frozen in", 16'(d), 16'h0096);
		fbm.freeze_cmd(1'b0);
		$display("data test done");
	endtask
	task automatic t_save();
		@(posedge clk_sys_i);
		cfg_save_i <= 1'b1;
		@(posedge clk_sys_i);
		cfg_save_i <= 1'b0;
		#1 chk("store", 16'(cfg_store_o), 16'h0001);
		for (int i = 0; i < 4; i++)
			ew(11'h400, 8'h02);
		#1 chk("full", 16'(eth_wr_ready_o), 16'h0000);
		chk("mode held", 16'(master_mode_o), 16'h0003);
		@(posedge clk_sys_i);
		cfg_store_done_i <= 1'b1;
		@(posedge clk_sys_i);
		cfg_store_done_i <= 1'b0;
		#1 chk("restart", 16'(restart_o), 16'h0001);
		cyc(8);
		chk("mode after", 16'(master_mode_o), 16'h0002);
		chk("drained", 16'(eth_wr_ready_o), 16'h0001);
		$display("save test done");
	endtask
	task automatic t_poll();
		int nr;
		int ng;
		int fr;
		nr = 0;
		ng = 0;
		fr = -1;
		#1 chk("station high", 16'(station_ok_o), 16'h0000);
		chk("delay ok", 16'(reply_delay_ok_o), 16'h0001);
		@(posedge clk_sys_i);
		req_station_i <= 7'h7E;
		req_start_i <= 1'b1;
		@(posedge clk_sys_i);
		req_start_i <= 1'b0;
		for (int i = 0; i < 60; i++)
		begin
			#1;
			if (req_retry_o === 1'b1 && fr < 0)
				fr = i;
			nr += int'(req_retry_o === 1'b1);
			ng += int'(req_giveup_o === 1'b1);
			@(posedge clk_sys_i);
		end
		chk("station ok", 16'(station_ok_o), 16'h0001);
		// two slot units of five cycles, plus entry and retry state
		chk("slot wait", 16'(fr), 16'h000C);
		chk("retries", 16'(nr), 16'h0002);
		chk("give up", 16'(ng), 16'h0001);
		for (int k = 1; k < 7; k++)
		begin
			token_round_i <= 1'b1;
			@(posedge clk_sys_i);
			token_round_i <= 1'b0;
			#1 chk("scan", 16'(scan_due_o), 16'(k % 3 == 0));
			@(posedge clk_sys_i);
		end
		// sixteen rotation units of five cycles after the last round
		cyc(68);
		chk("rotation on time", 16'(rotation_late_o), 16'h0000);
		cyc(20);
		chk("rotation late", 16'(rotation_late_o), 16'h0001);
		@(posedge clk_sys_i);
		req_start_i <= 1'b1;
		@(posedge clk_sys_i);
		req_start_i <= 1'b0;
		reply_seen_i <= 1'b1;
		nr = 0;
		for (int i = 0; i < 20; i++)
		begin
			#1;
			nr += int'(req_retry_o === 1'b1 || req_giveup_o === 1'b1);
			@(posedge clk_sys_i);
		end
		reply_seen_i <= 1'b0;
		chk("answered", 16'(nr), 16'h0000);
		$display("poll test done");
	endtask
	task automatic t_fault();
		logic [7:0] d;
		@(posedge clk_sys_i);
		cfg_sub_wr_i <= 1'b1;
		cfg_sub_addr_i <= 11'h010;
		cfg_sub_data_i <= 8'hE1;
		@(posedge clk_sys_i);
		cfg_sub_wr_i <= 1'b0;
		ew(11'h010, 8'h11);
		cyc(900);
		chk("fault early", 16'(module_fault_o), 16'h0000);
		cyc(200);
		chk("fault", 16'(module_fault_o), 16'h0001);
		fbm.get(11'h010, d);
		chk("substitute", 16'(d), 16'h00E1);
		ew(11'h011, 8'h44);
		cyc(4);
		chk("fault cleared", 16'(module_fault_o), 16'h0000);
		fbm.get(11'h010, d);
		chk("live data", 16'(d), 16'h0011);
		$display("fault test done");
	endtask
	initial
	begin
		#40000;
		err_count++;
		finish_test();
	end
	initial
	begin
		repeat (2) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		#1 chk("reset mode", 16'(master_mode_o), 16'h0001);
		chk("reset ready", 16'(eth_wr_ready_o), 16'h0001);
		t_mode();
		t_data();
		t_save();
		t_poll();
		t_fault();
		finish_test();
	end
endmodule
